// ===== pkg/fws_pkg.sv
// Package for the flash write-status host controller.
// Assumes a 20 MHz mclk_i and an asynchronous-read NOR flash on the pins.
package fws_pkg;
  // APB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_RDAT = 8'h10;
  // Control bits
  localparam int CTRL_GO = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_ABORT = 2;
  // Status bits
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RDY = 3;
  localparam int ST_SUSP = 4;
  // Data bit positions of the status byte
  localparam int POLL_BIT = 7;
  localparam int TOG1_BIT = 6;
  localparam int TMO_BIT = 5;
  localparam int TOG2_BIT = 2;
  // Timing: one flash read cycle in ns, rounded up to clocks
  localparam int CLK_NS = 50;
  localparam int RD_NS = 100;
  localparam int RD_CYC = (RD_NS + CLK_NS - 1) / CLK_NS;
  // Reset command written after a failed operation
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  typedef enum logic [3:0] {
    FWS_IDLE = 4'b0000,
    FWS_RD1 = 4'b0001,
    FWS_RD2 = 4'b0010,
    FWS_CHK = 4'b0011,
    FWS_RD3 = 4'b0100,
    FWS_CHK2 = 4'b0101,
    FWS_RST = 4'b0110,
    FWS_ARR = 4'b0111,
    FWS_END = 4'b1000
  } fws_state_t;
endpackage

// ===== pkg/fws_rd_if.sv
// Interface between the status engine and the flash read-cycle driver.
// Assumes a single clock domain.
`timescale 1ns/10ps
`default_nettype none
interface fws_rd_if;
  logic req;
  logic wr;
  logic [19:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport master (output req, wr, addr, wdata, input done, rdata);
  modport slave (input req, wr, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// ===== rtl/fws_cycle.sv
// Flash bus cycle driver: one asynchronous read or write per request.
// Assumes flash pins are synchronous to mclk_i and a fixed cycle length.
`timescale 1ns/10ps
`default_nettype none
module fws_cycle import fws_pkg::*; (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Engine side
  fws_rd_if.slave rd,
  // Flash pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [19:0] fa_o,
  output logic [7:0] fd_o,
  output logic fd_oe_o,
  input wire logic [7:0] fd_i
);
  typedef struct packed {
    logic act;
    logic [3:0] cnt;
    logic ce_n, oe_n, we_n, fd_oe, done;
    logic [19:0] a;
    logic [7:0] d, rd;
  } fws_cyc_t;
  fws_cyc_t s, next_s;
  // Each cycle toggles chip select, so every read counts as a new read cycle
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (!s.act && rd.req && !s.done) begin
      next_s.act = 1'b1;
      next_s.cnt = 4'(RD_CYC);
      next_s.a = rd.addr;
      next_s.d = rd.wdata;
      next_s.ce_n = 1'b0;
      next_s.oe_n = rd.wr;
      next_s.we_n = !rd.wr;
      next_s.fd_oe = rd.wr;
    end else if (s.act) begin
      if (s.cnt == 4'd0) begin
        next_s.act = 1'b0;
        next_s.done = 1'b1;
        next_s.rd = fd_i;
        next_s.ce_n = 1'b1;
        next_s.oe_n = 1'b1;
        next_s.we_n = 1'b1;
        next_s.fd_oe = 1'b0;
      end else begin
        next_s.cnt = s.cnt - 4'd1;
      end
    end
  end
  // State register
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      s <= '0;
      s.ce_n <= 1'b1;
      s.oe_n <= 1'b1;
      s.we_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
  assign rd.done = s.done;
  assign rd.rdata = s.rd;
  assign ce_n_o = s.ce_n;
  assign oe_n_o = s.oe_n;
  assign we_n_o = s.we_n;
  assign fa_o = s.a;
  assign fd_o = s.d;
  assign fd_oe_o = s.fd_oe;
endmodule
`default_nettype wire

// ===== rtl/fws_host.sv
// Host controller that monitors a flash program or erase to completion.
// Assumes software has already issued the command sequence to the flash.
// How it works
// - Host polls at an address software gives, never inside a protected sector.
// - After status looks done, host reads one more cycle for full data.
// - Read full byte twice; unchanged toggle bit means operation complete.
// - If toggling and timeout flag high, recheck; still toggling is failure, send reset.
// - After an abort, the next start begins again from the first double read.
// - Status address is the programmed address or an address in an erasing sector.
// - Polling is rechecked after timeout flag before declaring failure.
// - Status address must lie in the busy bank; software supplies it.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module fws_host import fws_pkg::*; (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Flash pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [19:0] fa_o,
  output logic [7:0] fd_o,
  output logic fd_oe_o,
  input wire logic [7:0] fd_i,
  input wire logic ready_busy_out_i
);
  typedef struct packed {
    fws_state_t st;
    logic mode;
    logic [19:0] addr;
    logic [7:0] exp;
    logic [7:0] first, last, arr;
    logic busy, done, fail, rdy, susp;
    logic req, wr;
    logic [7:0] wdata;
    logic [31:0] prdata;
    logic pready, pslverr;
  } fws_host_t;
  fws_host_t s, next_s;
  fws_rd_if rd ();
  logic [7:0] b;
  logic tog_moved, poll_done;
  logic abort_wr;
  // Cycle driver
  fws_cycle u_cyc (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .rd(rd),
    .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o),
    .we_n_o(we_n_o),
    .fa_o(fa_o),
    .fd_o(fd_o),
    .fd_oe_o(fd_oe_o),
    .fd_i(fd_i)
  );
  assign rd.req = s.req;
  assign rd.wr = s.wr;
  assign rd.addr = s.addr;
  assign rd.wdata = s.wdata;
  assign b = rd.rdata;
  // Completion tests for the two methods
  assign tog_moved = b[TOG1_BIT] != s.first[TOG1_BIT];
  assign poll_done = s.mode ? (b[POLL_BIT] == 1'b1)
                            : (b[POLL_BIT] == s.exp[POLL_BIT]);
  // Abort write, applied after the sequence so a finishing cycle cannot undo it
  assign abort_wr = psel_i && penable_i && !s.pready && pwrite_i
                    && (paddr_i == REG_CTRL) && pwdata_i[CTRL_ABORT];
  // Register access and monitoring sequence
  always_comb begin
    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.rdy = ready_busy_out_i;
    // APB: answer one cycle into the access phase, after one wait state
    if (psel_i && penable_i && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = RST_VAL;
      if (pwrite_i) begin
        case (paddr_i)
          REG_CTRL: begin
            if (pwdata_i[CTRL_ABORT]) begin
              next_s.st = FWS_IDLE;
              next_s.busy = 1'b0;
            end else if (pwdata_i[CTRL_GO] && s.st == FWS_IDLE) begin
              next_s.mode = pwdata_i[CTRL_MODE];
              next_s.st = FWS_RD1;
              next_s.busy = 1'b1;
              next_s.done = 1'b0;
              next_s.fail = 1'b0;
              next_s.susp = 1'b0;
            end
          end
          REG_ADDR: next_s.addr = pwdata_i[19:0];
          REG_DATA: next_s.exp = pwdata_i[7:0];
          default: next_s.pslverr = 1'b1;
        endcase
      end else begin
        case (paddr_i)
          REG_CTRL: next_s.prdata = {30'd0, s.mode, 1'b0};
          REG_ADDR: next_s.prdata = {12'd0, s.addr};
          REG_DATA: next_s.prdata = {24'd0, s.exp};
          REG_STAT: next_s.prdata = {24'd0, s.last[TOG2_BIT], 2'd0,
                                     s.susp, s.rdy, s.fail, s.done, s.busy};
          REG_RDAT: next_s.prdata = {24'd0, s.arr};
          default: next_s.pslverr = 1'b1;
        endcase
      end
    end
    // Flash request handshake: drop request once a cycle completes
    if (rd.done) begin
      next_s.req = 1'b0;
    end
    case (s.st)
      FWS_IDLE: next_s.req = 1'b0;
      FWS_RD1: begin
        next_s.wr = 1'b0;
        if (rd.done) begin
          next_s.first = b;
          next_s.st = FWS_RD2;
        end else next_s.req = 1'b1;
      end
      FWS_RD2: begin
        if (rd.done) begin
          next_s.last = b;
          next_s.st = FWS_CHK;
          if (!tog_moved && poll_done) begin
            next_s.st = FWS_ARR;
            next_s.susp = ready_busy_out_i && s.mode;
          end else if (b[TMO_BIT]) begin
            next_s.first = b;
            next_s.st = FWS_RD3;
          end else begin
            next_s.first = b;
            next_s.st = FWS_RD2;
          end
        end else next_s.req = 1'b1;
      end
      FWS_RD3: begin
        if (rd.done) begin
          next_s.last = b;
          if (!tog_moved && poll_done) next_s.st = FWS_ARR;
          else next_s.st = FWS_RST;
        end else next_s.req = 1'b1;
      end
      FWS_RST: begin
        next_s.wr = 1'b1;
        next_s.wdata = CMD_RESET;
        if (rd.done) begin
          next_s.wr = 1'b0;
          next_s.fail = 1'b1;
          next_s.busy = 1'b0;
          next_s.st = FWS_IDLE;
        end else next_s.req = 1'b1;
      end
      FWS_ARR: begin
        next_s.wr = 1'b0;
        if (rd.done) begin
          next_s.arr = b;
          next_s.done = 1'b1;
          next_s.busy = 1'b0;
          next_s.st = FWS_IDLE;
        end else next_s.req = 1'b1;
      end
      default: next_s.st = FWS_IDLE;
    endcase
    // Abort wins over the state, busy, request and write the sequence sets in the same cycle
    if (abort_wr) begin
      next_s.st = FWS_IDLE;
      next_s.busy = 1'b0;
      next_s.req = 1'b0;
      next_s.wr = 1'b0;
    end
  end
  // State register
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      s <= '0;
      s.st <= FWS_IDLE;
    end else begin
      s <= next_s;
    end
  end
  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
endmodule
`default_nettype wire

// ===== tb/fws_host_sva.sv
// Checker on the flash status controller pins and APB answer.
// Assumes bind into fws_host, one clock, sync active-low reset.
`timescale 1ns/10ps
`default_nettype none
module fws_host_sva import fws_pkg::*; (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Flash pins
  input wire logic ce_n_o,
  input wire logic oe_n_o,
  input wire logic we_n_o,
  input wire logic [19:0] fa_o,
  input wire logic [7:0] fd_o,
  input wire logic fd_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // A read holds both strobes low three clocks
  sequence rd_hold;
    (!oe_n_o && !ce_n_o) [*3];
  endsequence
  AST_RD_LEN: assert property ($fell(oe_n_o) |-> rd_hold ##1 oe_n_o)
    else $error("read strobe length wrong");
  AST_CE_RD: assert property (!oe_n_o |-> !ce_n_o)
    else $error("read without chip select");
  AST_NO_CLASH: assert property (!(!oe_n_o && !we_n_o))
    else $error("read and write strobes together");
  AST_CMD: assert property (fd_oe_o |-> fd_o == CMD_RESET)
    else $error("driven byte is not the reset command");
  AST_WR_OE: assert property ($fell(we_n_o) |-> fd_oe_o)
    else $error("write strobe without data drive");
  AST_ADDR: assert property (!ce_n_o && !$past(ce_n_o) |-> $stable(fa_o))
    else $error("address moved inside a cycle");
  AST_CE_GAP: assert property ($rose(ce_n_o) |=> ce_n_o)
    else $error("chip select gap shorter than two clocks");
  AST_RDY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  AST_RDY_CAUSE: assert property (pready_o |-> psel_i && penable_i && $past(penable_i))
    else $error("pready without access phase");
  AST_ERR: assert property (pslverr_o |-> pready_o)
    else $error("pslverr outside answer");
endmodule
bind fws_host fws_host_sva i_sva (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .ce_n_o(ce_n_o),
  .oe_n_o(oe_n_o), .we_n_o(we_n_o), .fa_o(fa_o), .fd_o(fd_o), .fd_oe_o(fd_oe_o));
`default_nettype wire

// ===== tb/fws_flash_mdl.sv
// Behavioural busy bank of the flash: status bytes while busy.
// Assumes pins synchronous to mclk_i; bench sets the operation.
`timescale 1ns/10ps
`default_nettype none
module fws_flash_mdl (
  // Clock and pins
  input wire logic mclk_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [7:0] fd_i,
  input wire logic fd_oe_i,
  // Bench control
  input wire logic go_i,
  input wire logic erase_i,
  input wire logic stuck_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] nrd_i,
  // Outputs
  output logic [7:0] fd_o,
  output logic ready_busy_out_o,
  output logic rst_seen_o
);
  logic busy = 1'b0, tog = 1'b0, prev_oe = 1'b1, rd_on;
  logic [7:0] cnt = 8'h00, last = 8'h00, stat;
  assign rd_on = !ce_n_i && !oe_n_i;
  // Status byte: polling, toggles, timeout flag
  assign stat = {erase_i ? 1'b0 : ~data_i[7], tog, stuck_i && cnt == 0, 2'b00,
    erase_i & tog, 2'b00};
  // Each read start while busy toggles; read nrd_i+1 ends the run unless stuck_i is set
  always @(posedge mclk_i) begin
    prev_oe <= oe_n_i;
    if (go_i) begin
      busy <= 1'b1;
      cnt <= nrd_i;
      rst_seen_o <= 1'b0;
    end else if (prev_oe && rd_on && busy) begin
      tog <= !tog;
      if (cnt != 0) cnt <= cnt - 8'h01;
      else if (!stuck_i) busy <= 1'b0;
    end
    if (!we_n_i && fd_oe_i && fd_i == 8'hf0) begin
      busy <= 1'b0;
      rst_seen_o <= 1'b1;
    end
    if (rd_on) last <= fd_o;
  end
  // Released bus shows the inverse of the last byte
  assign fd_o = rd_on ? (busy ? stat : data_i) : ~last;
  assign ready_busy_out_o = !busy;
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Bench: APB master, flash model, queued expected results.
// Assumes fws_host, fws_flash_mdl and the checker bind.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fws_pkg::*;
  logic mclk_i = 0, rstn_i = 0, psel = 0, pen = 0, pwr = 0, fgo = 0, fer = 0, fstk = 0;
  logic pready, pslverr, ce_n, oe_n, we_n, fd_oe, rb, rseen;
  logic [7:0] pad = 0, fdat = 0, fnrd = 0, fdo, fdi, dat;
  logic [31:0] pwd = 0, rd, prdata, seed = 32'hf842;
  logic [19:0] fa;
  logic [19:0] fadr = 20'h0_0000;
  logic ce_q = 1;
  logic [64:0] q, expq[$];
  int err_count = 0, tests_run = 0;
  fws_host i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pad), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .fa_o(fa),
    .fd_o(fdo), .fd_oe_o(fd_oe), .fd_i(fdi), .ready_busy_out_i(rb));
  fws_flash_mdl i_mdl (.mclk_i(mclk_i), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .fd_i(fdo), .fd_oe_i(fd_oe), .go_i(fgo), .erase_i(fer), .stuck_i(fstk), .data_i(fdat),
    .nrd_i(fnrd), .fd_o(fdi), .ready_busy_out_o(rb), .rst_seen_o(rseen));
  // Clock
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim();
    $display("checks=%0d errors=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; reads note {err, mask, value}
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [64:0] e);
    int n;
    n = 0;
    if (!w) expq.push_back(e);
    @(posedge mclk_i);
    psel <= 1;
    pwr <= w;
    pad <= a;
    pwd <= d;
    @(posedge mclk_i);
    pen <= 1;
    // Hold the request until pready is sampled high at a rising edge
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
      end_sim();
    end
    rd = prdata;
    psel <= 0;
    pen <= 0;
  endtask
  // Flash address checked at the start of every bus cycle
  always @(negedge mclk_i) begin
    if (ce_n === 1'b0 && ce_q) chk({13'h0, fa}, {13'h0, fadr});
    ce_q = (ce_n !== 1'b0);
  end
  // Read answers checked against the oldest note
  always @(negedge mclk_i) begin
    if (psel && pen && pready === 1'b1 && !pwr) begin
      q = expq.pop_front();
      if (q != 0) chk({pslverr, prdata & q[63:32]}, {q[64], q[31:0]});
    end
  end
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(0, REG_STAT, 0, '0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 200);
    if (n >= 200) begin
      err_count++;
      end_sim();
    end
  endtask
  // Program, erase, zero-wait boundary and timeout failure
  initial begin
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1;
    apb(0, 8'h20, 0, {1'b1, 64'h0});
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      dat = i[0] ? (seed[7:0] | 8'h80) : seed[7:0];
      fdat <= dat;
      fer <= i[0];
      fstk <= (i == 3);
      fnrd <= (i == 0) ? 8'h00 : {5'h0, seed[10:8]} + 8'h01;
      fadr = seed[27:8];
      apb(1, REG_ADDR, {12'h0, seed[27:8]}, '0);
      apb(0, REG_ADDR, 0, {1'b0, 32'h000f_ffff, 12'h0, seed[27:8]});
      apb(1, REG_DATA, {24'h0, dat}, '0);
      fgo <= 1;
      @(posedge mclk_i);
      fgo <= 0;
      apb(1, REG_CTRL, {30'h0, i[0], 1'b1}, '0);
      wait_idle();
      apb(0, REG_STAT, 0, {1'b0, (i == 3) ? 32'h0000_001f : 32'h0000_009f,
        (i == 3) ? 32'h0000_000c : {24'h0, dat[2], 2'b00, i[0], 4'b1010}});
      apb(0, REG_CTRL, 0, {1'b0, 32'h0000_0002, 30'h0, i[0], 1'b0});
      if (i != 3) apb(0, REG_RDAT, 0, {33'hff, 24'h0, dat});
      chk({32'h0, rseen}, {32'h0, i == 3});
    end
    // Abort a running check, then restart it from the first double read
    fstk <= 1'b1;
    fer <= 1'b0;
    fnrd <= 8'h03;
    fgo <= 1'b1;
    @(posedge mclk_i);
    fgo <= 1'b0;
    apb(1, REG_CTRL, 32'h0000_0001, '0);
    apb(1, REG_CTRL, 32'h0000_0004, '0);
    apb(0, REG_STAT, 0, {1'b0, 32'h0000_0003, 32'h0000_0000});
    fstk <= 1'b0;
    apb(1, REG_CTRL, 32'h0000_0001, '0);
    wait_idle();
    apb(0, REG_STAT, 0, {1'b0, 32'h0000_0007, 32'h0000_0002});
    end_sim();
  end
  // Run limit
  initial begin
    repeat (90000) @(posedge mclk_i);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
